// File: logic/wit_core.sv
// Behaviour
// - wipe base times on-phase and after-wash hold; pause base times only pause.
// - pause request active either polarity; intermittent only if washer idle; steady-wipe does not block it.
// - after debounce of pause request, relay on for 16 internal periods.
// - after each on-phase, relay off for 144 internal periods of pause base.
// - on/pause cycle repeats while pause request stays detected active.
// - pause request dropping before debounce ends causes no action.
// - pause request removed during on-phase: on-phase completes before stopping.
// - washer debounced active turns relay on while washer stays active.
// - after washer inactive, relay stays on 96 more internal periods.
// - washer activation shorter than debounce is ignored.
// - steady-wipe request forces relay on regardless of other inputs, except while enable is low.
// - steady-wipe acts on relay only; timing sequences are untouched.
// - washer during pause request: hold plus one on-phase, then resume cycling.
// - pause request and washer sampled each internal clock; accepted when two samples agree.
// - internal clock is one time-base period; debounce one to two of them.
// - debounce filters pause request and washer sense.
// - washer debounce in pause phase is clocked on the pause base.
module wit_core
    import wit_pkg::*;
(
    input  wire logic                  clock_i,
    input  wire logic                  reset_n_i,
    input  wire logic                  enable_i,
    input  wire logic                  pause_request_pos_i,
    input  wire logic                  pause_request_neg_i,
    input  wire logic                  washer_sense_i,
    input  wire logic                  steady_wipe_request_i,
    input  wire logic [WIT_TICK_W-1:0] wipe_time_base_i,
    input  wire logic [WIT_TICK_W-1:0] pause_time_base_i,
    output logic                       relay_o,
    output logic                       pause_phase_o,
    output logic                       tick_o
);
    import wit_pkg::*;

    wit_state_t            state;
    wit_state_t            next_state;
    logic [WIT_CNT_W-1:0]  count;
    logic [WIT_CNT_W-1:0]  next_count;
    logic                  pause_raw;
    logic                  pause_samp;
    logic                  pause_det;
    logic                  wash_samp;
    logic                  wash_det;
    logic                  use_pause_base;
    logic                  tick;
    logic                  hold_plus_on;
    logic                  next_hold_plus_on;
    logic                  seq_on;
    logic                  next_relay;

    // either polarity of the switch counts as a request
    assign pause_raw = pause_request_pos_i | pause_request_neg_i;

    // oscillator runs on the pause base only during the pause phase
    assign use_pause_base = (state == WIT_PAUSE);

    wit_tick_gen u_tick (
        .clock_i          (clock_i),
        .reset_n_i        (reset_n_i),
        .enable_i         (enable_i),
        .use_pause_base_i (use_pause_base),
        .wipe_len_i       (wipe_time_base_i),
        .pause_len_i      (pause_time_base_i),
        .tick_o           (tick)
    );

    // two agreeing samples on consecutive internal ticks accept a new level
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pause_samp <= 1'b0;
            pause_det  <= 1'b0;
            wash_samp  <= 1'b0;
            wash_det   <= 1'b0;
        end else if (enable_i && tick) begin
            pause_samp <= pause_raw;
            wash_samp  <= washer_sense_i;
            if (pause_samp == pause_raw) begin
                pause_det <= pause_raw;
            end
            if (wash_samp == washer_sense_i) begin
                wash_det <= washer_sense_i;
            end
        end
    end

    // sequencer; steady-wipe never enters here, so timing is not disturbed
    always_comb begin
        next_state        = state;
        next_count        = count;
        next_hold_plus_on = hold_plus_on;
        if (tick) begin
            next_count = count + 8'h01;
            unique case (state)
                WIT_IDLE: begin
                    next_count = WIT_CNT_ZERO;
                    if (wash_det) begin
                        next_state = WIT_WASH;
                    end else if (pause_det) begin
                        next_state = WIT_ON;
                    end
                end
                WIT_ON: begin
                    if (wash_det) begin
                        next_state = WIT_WASH;
                        next_count = WIT_CNT_ZERO;
                    end else if (count == WIT_ON_LAST) begin
                        // full on-phase completes unless the washer takes over, even if request dropped
                        next_state = pause_det ? WIT_PAUSE : WIT_IDLE;
                        next_count = WIT_CNT_ZERO;
                    end
                end
                WIT_PAUSE: begin
                    if (wash_det) begin
                        next_state = WIT_WASH;
                        next_count = WIT_CNT_ZERO;
                    end else if (!pause_det) begin
                        next_state = WIT_IDLE;
                    end else if (count == WIT_PAUSE_LAST) begin
                        next_state = WIT_ON;
                        next_count = WIT_CNT_ZERO;
                    end
                end
                WIT_WASH: begin
                    next_count = WIT_CNT_ZERO;
                    if (!wash_det) begin
                        next_state        = WIT_HOLD;
                        next_hold_plus_on = pause_det;
                    end
                end
                WIT_HOLD: begin
                    if (wash_det) begin
                        next_state = WIT_WASH;
                        next_count = WIT_CNT_ZERO;
                    end else if (count == WIT_HOLD_LAST) begin
                        next_count = WIT_CNT_ZERO;
                        next_state = hold_plus_on ? WIT_HOLD_ON : WIT_IDLE;
                    end
                end
                WIT_HOLD_ON: begin
                    if (wash_det) begin
                        next_state = WIT_WASH;
                        next_count = WIT_CNT_ZERO;
                    end else if (count == WIT_ON_LAST) begin
                        next_count = WIT_CNT_ZERO;
                        next_state = pause_det ? WIT_PAUSE : WIT_IDLE;
                    end
                end
            endcase
        end
    end

    // relay driven by sequence, or forced by the steady-wipe request
    assign seq_on     = (state == WIT_ON) || (state == WIT_WASH) ||
                        (state == WIT_HOLD) || (state == WIT_HOLD_ON);
    assign next_relay = seq_on || steady_wipe_request_i;

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state        <= WIT_IDLE;
            count        <= WIT_CNT_ZERO;
            hold_plus_on <= 1'b0;
            relay_o      <= 1'b0;
        end else if (enable_i) begin
            state        <= next_state;
            count        <= next_count;
            hold_plus_on <= next_hold_plus_on;
            relay_o      <= next_relay;
        end
    end

    assign pause_phase_o = use_pause_base;
    assign tick_o        = tick;

    // on-phase lasts exactly 16 ticks: after entering on, no exit within 15 ticks
    a_on_phase_len: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (state == WIT_ON && count < WIT_ON_LAST && tick && !wash_det)
        |=> (state == WIT_ON))
        else $error("on-phase ended early");

    a_on_complete: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (state == WIT_ON && !pause_det && count != WIT_ON_LAST && !wash_det)
        |=> state == WIT_ON)
        else $error("on-phase cut short by removed request");

    a_pause_to_on: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (enable_i && state == WIT_PAUSE && tick && count == WIT_PAUSE_LAST && pause_det &&
         !wash_det)
        |=> state == WIT_ON)
        else $error("pause did not return to on-phase");

    a_pause_relay_off: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        enable_i && state == WIT_PAUSE && !steady_wipe_request_i |=> !relay_o)
        else $error("relay on during pause phase");

    a_steady_force: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        enable_i && steady_wipe_request_i |=> relay_o)
        else $error("steady wipe did not force relay");

    a_steady_keeps: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        enable_i && !tick && $stable(steady_wipe_request_i) |=> $stable(state))
        else $error("state moved without internal tick");

    a_wash_relay: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        enable_i && state == WIT_WASH |=> relay_o)
        else $error("relay off while washing");

    a_hold_len: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (state == WIT_HOLD && tick && count < WIT_HOLD_LAST && !wash_det)
        |=> state == WIT_HOLD)
        else $error("after-wash hold ended early");

    a_debounce_agree: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        $changed(pause_det) |-> $past(tick) && $past(pause_samp) == pause_det)
        else $error("pause request accepted without two samples");

    a_idle_off: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (state == WIT_IDLE && !pause_det && !wash_det && tick) |=> state == WIT_IDLE)
        else $error("action without detected request");

    // idle relay follows only the steady-wipe request
    a_idle_relay_off: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        enable_i && state == WIT_IDLE && !steady_wipe_request_i |=> !relay_o)
        else $error("relay on while idle");

    // relay must be on through every on-phase
    a_on_relay: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        enable_i && state == WIT_ON |=> relay_o)
        else $error("relay off during on-phase");

    // relay must be on through the after-wash hold and its extra on-phase
    a_hold_relay: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        enable_i && (state == WIT_HOLD || state == WIT_HOLD_ON) |=> relay_o)
        else $error("relay off during after-wash hold");

    // detected request in idle starts an on-phase on the next tick
    a_idle_start: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        enable_i && tick && state == WIT_IDLE && pause_det && !wash_det |=> state == WIT_ON)
        else $error("detected request did not start wiping");

    // an on-phase always starts counting from zero
    a_idle_count_zero: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        enable_i && tick && state == WIT_IDLE |=> count == WIT_CNT_ZERO)
        else $error("stale count left in idle");

    // end of on-phase with request still held goes to pause
    a_on_to_pause: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        enable_i && tick && state == WIT_ON && count == WIT_ON_LAST && pause_det && !wash_det
        |=> state == WIT_PAUSE)
        else $error("on-phase not followed by pause");

    // end of on-phase with request gone stops the sequence
    a_on_to_idle: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        enable_i && tick && state == WIT_ON && count == WIT_ON_LAST && !pause_det && !wash_det
        |=> state == WIT_IDLE)
        else $error("on-phase not followed by stop");

    // pause keeps counting while the request stays
    a_pause_len: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        enable_i && tick && state == WIT_PAUSE && count < WIT_PAUSE_LAST && pause_det &&
        !wash_det |=> state == WIT_PAUSE)
        else $error("pause phase ended early");

    // pause abandoned once the request is no longer detected
    a_pause_drop: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        enable_i && tick && state == WIT_PAUSE && !pause_det && !wash_det |=> state == WIT_IDLE)
        else $error("pause went on without request");

    // washer takes over from any other phase, timer cleared
    a_wash_enter: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        enable_i && tick && wash_det && state != WIT_WASH
        |=> state == WIT_WASH && count == WIT_CNT_ZERO)
        else $error("washer did not take over");

    // washing lasts as long as the washer stays detected
    a_wash_stays: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        enable_i && tick && state == WIT_WASH && wash_det |=> state == WIT_WASH)
        else $error("washing left while washer active");

    // end of washing starts the hold and records the pause request
    a_wash_exit: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        enable_i && tick && state == WIT_WASH && !wash_det
        |=> state == WIT_HOLD && hold_plus_on == $past(pause_det))
        else $error("washing did not end in hold");

    // hold without pause request ends in idle
    a_hold_to_idle: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        enable_i && tick && state == WIT_HOLD && count == WIT_HOLD_LAST && !wash_det &&
        !hold_plus_on |=> state == WIT_IDLE)
        else $error("hold did not end in idle");

    // hold with pause request adds one on-phase
    a_hold_to_on: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        enable_i && tick && state == WIT_HOLD && count == WIT_HOLD_LAST && !wash_det &&
        hold_plus_on |=> state == WIT_HOLD_ON)
        else $error("hold did not add an on-phase");

    // extra on-phase after washing runs its full length
    a_hold_on_len: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        enable_i && tick && state == WIT_HOLD_ON && count < WIT_ON_LAST && !wash_det
        |=> state == WIT_HOLD_ON)
        else $error("extra on-phase ended early");

    // extra on-phase hands back to intermittent cycling
    a_hold_on_resume: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        enable_i && tick && state == WIT_HOLD_ON && count == WIT_ON_LAST && !wash_det &&
        pause_det |=> state == WIT_PAUSE)
        else $error("cycling not resumed after wash");

    // washer acceptance needs two agreeing samples as well
    a_wash_agree: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        $changed(wash_det) |-> $past(tick) && $past(wash_samp) == wash_det)
        else $error("washer accepted without two samples");

    // counters never pass the end of their phase
    a_on_bound: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        state == WIT_ON |-> count <= WIT_ON_LAST)
        else $error("on-phase count overran");

    a_pause_bound: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        state == WIT_PAUSE |-> count <= WIT_PAUSE_LAST)
        else $error("pause count overran");

    a_hold_bound: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        state == WIT_HOLD |-> count <= WIT_HOLD_LAST)
        else $error("hold count overran");

    // low enable must freeze every piece of state, relay included
    a_enable_freeze: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        !enable_i |=> $stable(state) && $stable(count) && $stable(relay_o) &&
        $stable(pause_det) && $stable(wash_det))
        else $error("state moved while enable low");
endmodule

// File: logic/wit_pkg.sv
package wit_pkg;
    // time base periods in system clocks per internal clock period (one time-base period each)
    localparam int WIT_WIPE_TICK_DEF  = 64;
    localparam int WIT_PAUSE_TICK_DEF = 32;
    localparam int WIT_TICK_W         = 24;
    // phase lengths in internal clock periods (each period = one time-base period)
    localparam int WIT_ON_PERIODS     = 16;
    localparam int WIT_PAUSE_PERIODS  = 144;
    localparam int WIT_HOLD_PERIODS   = 96;
    localparam int WIT_CNT_W          = 8;
    localparam logic [WIT_CNT_W-1:0] WIT_ON_LAST    = 8'h0F;
    localparam logic [WIT_CNT_W-1:0] WIT_PAUSE_LAST = 8'h8F;
    localparam logic [WIT_CNT_W-1:0] WIT_HOLD_LAST  = 8'h5F;
    localparam logic [WIT_CNT_W-1:0] WIT_CNT_ZERO   = 8'h00;

    typedef enum logic [2:0] {
        WIT_IDLE,
        WIT_ON,
        WIT_PAUSE,
        WIT_WASH,
        WIT_HOLD,
        WIT_HOLD_ON
    } wit_state_t;
endpackage

// File: logic/wit_tick_gen.sv
// internal oscillator model: one tick per internal clock falling edge
module wit_tick_gen
    import wit_pkg::*;
(
    input  wire logic                  clock_i,
    input  wire logic                  reset_n_i,
    input  wire logic                  enable_i,
    input  wire logic                  use_pause_base_i,
    input  wire logic [WIT_TICK_W-1:0] wipe_len_i,
    input  wire logic [WIT_TICK_W-1:0] pause_len_i,
    output logic                       tick_o
);
    logic [WIT_TICK_W-1:0] count;
    logic [WIT_TICK_W-1:0] period;
    logic                  wrap;

    // period follows whichever time base is selected now
    assign period = use_pause_base_i ? pause_len_i : wipe_len_i;
    assign wrap   = (count + 24'h00_0001) >= period;

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count  <= '0;
            tick_o <= 1'b0;
        end else if (enable_i) begin
            count  <= wrap ? '0 : count + 24'h00_0001;
            tick_o <= wrap;
        end
    end
endmodule

// File: sim/wit_far_side.sv
// far side: driver switches, washer pump line and the relay load
module wit_far_side (
    input  wire logic        clock_i,
    input  wire logic        tick_i,
    input  wire logic        relay_i,
    input  wire logic [3:0]  cmd_i,
    output logic      [3:0]  lines_o,
    output logic      [15:0] last_len_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] cnt;
    logic        prev;
    initial begin
        lines_o = 4'h0;
        last_len_o = 16'h0000;
        cnt = 16'h0000;
        prev = 1'b0;
    end
    // contacts change just after the edge, one clock behind the command
    always @(posedge clock_i) lines_o <= #1 cmd_i;
    // relay load: internal periods spent in the level just left
    always @(posedge clock_i) begin
        if (relay_i !== prev) begin
            last_len_o <= cnt;
            cnt <= 16'(tick_i);
        end else begin
            cnt <= cnt + 16'(tick_i);
        end
        prev <= relay_i;
    end
endmodule

// File: sim/test_wiper_interval_timer.sv
module test_wiper_interval_timer;
    timeunit 1ns;
    timeprecision 100ps;
    import wit_pkg::*;
    localparam int WB = 4;
    localparam int PB = 2;
    logic        clock_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic [3:0]  cmd = 4'h0;
    logic        en = 1'b1;
    logic [3:0]  lines;
    logic        relay;
    logic        pph;
    logic        tick;
    logic [15:0] last_len;
    int          err_count = 0;
    int          compares = 0;
    int          cycles = 0;
    int          t;
    int          t0;

    // small time bases keep the long phases short
    wit_core u_dut (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .enable_i(en),
        .pause_request_pos_i(lines[0]), .pause_request_neg_i(lines[1]),
        .washer_sense_i(lines[2]), .steady_wipe_request_i(lines[3]),
        .wipe_time_base_i(24'(WB)), .pause_time_base_i(24'(PB)),
        .relay_o(relay), .pause_phase_o(pph), .tick_o(tick)
    );
    wit_far_side u_far (
        .clock_i(clock_i), .tick_i(tick), .relay_i(relay),
        .cmd_i(cmd), .lines_o(lines), .last_len_o(last_len)
    );

    task automatic conclude();
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    function automatic logic in_rng(input int v, input int lo, input int hi);
        return v >= lo && v <= hi;
    endfunction
    task automatic clk(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    // bounded wait for a relay level; one extra clock lets the load update
    task automatic wait_relay(input logic lvl, input int lim, output int dt);
        dt = 0;
        while (relay !== lvl && dt < lim) begin
            clk(1);
            dt++;
        end
        check("relay level", relay, 16'(lvl));
        clk(1);
    endtask

    initial forever #2.5 clock_i = ~clock_i;
    // hang guard, well above the longest path through the tests
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 30000) begin
            err_count++;
            conclude();
        end
    end

    initial begin
        t = $urandom(32'hc122);
        clk(5);
        reset_n_i = 1'b1;
        clk(2);
        check("relay idle", relay, 1'b0);
        // both polarities, request dropped inside the second on-phase
        for (int p = 0; p < 2; p++) begin
            cmd[p] = 1'b1;
            wait_relay(1'b1, 20 * WB, t);
            check("debounce", in_rng(t, WB, 3 * WB + 3), 1'b1);
            wait_relay(1'b0, 20 * WB, t);
            check("on length", in_rng(last_len, 16, 17), 1'b1);
            check("pause base", pph, 1'b1);
            wait_relay(1'b1, 200 * PB, t);
            check("pause length", in_rng(last_len, 144, 145), 1'b1);
            check("pause time", in_rng(t, 143 * PB, 145 * PB + WB + 4), 1'b1);
            check("cycle again", relay, 1'b1);
            clk($urandom_range(1, 8 * WB));
            cmd[p] = 1'b0;
            wait_relay(1'b0, 20 * WB, t);
            check("on completes", in_rng(last_len, 16, 17), 1'b1);
            clk(200 * PB);
            check("stopped", relay, 1'b0);
        end
        // one-clock glitches can never meet two agreeing samples
        for (int k = 0; k < 6; k++) begin
            cmd[$urandom_range(0, 2)] = 1'b1;
            clk(1);
            cmd = 4'h0;
            clk(4 * WB);
            check("glitch", relay, 1'b0);
        end
        // washer alone: on while pumping, then the hold
        cmd[2] = 1'b1;
        wait_relay(1'b1, 20 * WB, t);
        check("wash debounce", in_rng(t, WB, 3 * WB + 3), 1'b1);
        clk($urandom_range(10, 60));
        check("wash on", relay, 1'b1);
        // low enable freezes the block: relay and phase must hold still
        en = 1'b0;
        clk($urandom_range(10, 40));
        check("frozen relay", relay, 1'b1);
        check("frozen phase", pph, 1'b0);
        en = 1'b1;
        clk(1);
        cmd[2] = 1'b0;
        wait_relay(1'b0, 120 * WB, t);
        check("after wash", in_rng(t, 97 * WB, 100 * WB + 3), 1'b1);
        // steady wipe in mid-pause must leave the pause timing alone
        cmd[0] = 1'b1;
        wait_relay(1'b1, 20 * WB, t);
        wait_relay(1'b0, 20 * WB, t);
        t0 = cycles;
        clk($urandom_range(20, 100));
        cmd[3] = 1'b1;
        clk(2);
        check("steady on", relay, 1'b1);
        clk($urandom_range(1, 40));
        cmd[3] = 1'b0;
        clk(2);
        check("steady off", relay, 1'b0);
        check("pause kept", pph, 1'b1);
        wait_relay(1'b1, 200 * PB, t);
        check("pause total", in_rng(cycles - t0, 143 * PB, 145 * PB + WB + 5), 1'b1);
        // wash during an on-phase: hold plus one on-phase, then cycling
        cmd[2] = 1'b1;
        clk($urandom_range(30, 60));
        check("wash over wipe", relay, 1'b1);
        cmd[2] = 1'b0;
        wait_relay(1'b0, 130 * WB, t);
        check("hold plus on", in_rng(t, 112 * WB, 116 * WB + 3), 1'b1);
        wait_relay(1'b1, 200 * PB, t);
        check("resume", in_rng(t, 143 * PB, 145 * PB + WB + 4), 1'b1);
        cmd[0] = 1'b0;
        wait_relay(1'b0, 20 * WB, t);
        conclude();
    end
endmodule
